/* inc/vcrs_params.svh */
// timing counts and code constants for the voltage code reference stepper
// assumes a 10 MHz system clock
`ifndef VCRS_PARAMS_SVH
`define VCRS_PARAMS_SVH
`define VCRS_CLK_HZ 10000000
`define VCRS_SAMPLE_HZ 5500000
`define VCRS_STEP_HZ 345000
`define VCRS_SAMPLE_DIV ((`VCRS_CLK_HZ + `VCRS_SAMPLE_HZ - 1) / `VCRS_SAMPLE_HZ)
`define VCRS_STEP_DIV (`VCRS_CLK_HZ / `VCRS_STEP_HZ)
`define VCRS_QUAL_CNT 3
`define VCRS_OFF_CNT 4
`define VCRS_CODE_W 8
`define VCRS_OFF_CODE_A 8'h00
`define VCRS_OFF_CODE_B 8'hff
`define VCRS_NOLOAD_CODE 8'h1f
`endif

/* inc/vcrs_pkg.sv */
// types for the voltage code reference stepper
// no assumptions
package vcrs_pkg;
  typedef enum logic [1:0] {VCRS_IDLE, VCRS_RUN, VCRS_OFF} vcrs_state_t;
endpackage : vcrs_pkg

/* rtl/vcrs_divider.sv */
// one-cycle enable pulse divider
// assumes one clock domain
`timescale 1ns/1ns
module vcrs_divider #(
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // tick
  output logic tick_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end
endmodule : vcrs_divider

/* rtl/vcrs_top.sv */
// voltage code qualifier and reference dac stepper
// assumes voltage_code_in and enable_in are asynchronous pins
`timescale 1ns/1ns
`include "vcrs_params.svh"

// What this block does
// - sample the voltage code on every sampling clock edge in both modes.
// - accept a changed code after three equal consecutive samples.
// - in stepwise mode load the dac at once with the accepted code.
// - in stepwise mode large jumps are still followed per validated code.
// - in slewing mode move the dac one step per step clock to the target.
// - an off code needs four equal consecutive samples.
// - an off code latches regulation off until enable goes low.
// - the no-load code in slewing mode blocks the start-up.
// - power good goes low on off latch until enable and a new start.
module vcrs_top #(
  parameter int CODE_W = `VCRS_CODE_W
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control pins
  input wire logic enable_in,
  input wire logic stepwise_mode_in,
  input wire logic [CODE_W-1:0] voltage_code_in,
  // outputs
  output logic [CODE_W-1:0] dac_code_out,
  output logic regulate_out,
  output logic off_latched_out,
  output logic power_good_flag_out
);
  localparam logic [2:0] QUAL = 3'(`VCRS_QUAL_CNT);
  localparam logic [2:0] OFFQ = 3'(`VCRS_OFF_CNT);
  localparam logic [CODE_W-1:0] OFF_A = CODE_W'(`VCRS_OFF_CODE_A);
  localparam logic [CODE_W-1:0] OFF_B = CODE_W'(`VCRS_OFF_CODE_B);
  localparam logic [CODE_W-1:0] NOLOAD = CODE_W'(`VCRS_NOLOAD_CODE);

  function automatic logic is_off(input logic [CODE_W-1:0] c, input logic sw);
    is_off = sw ? (c == OFF_A || c == OFF_B) : (c == NOLOAD);
  endfunction : is_off

  logic [CODE_W-1:0] code_s1, code_s2;
  logic en_s1, en_s2, mode_s1, mode_s2;
  logic sample_tick, step_tick;
  logic [CODE_W-1:0] cand, target;
  logic [2:0] cnt;
  logic accepted, off_seen;
  logic new_req;
  logic qualified;
  logic [CODE_W-1:0] hist_1, hist_2, hist_3;
  vcrs_pkg::vcrs_state_t state;

  vcrs_divider #(.DIV(`VCRS_SAMPLE_DIV)) u_sample_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(sample_tick)
  );

  vcrs_divider #(.DIV(`VCRS_STEP_DIV)) u_step_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(step_tick)
  );

  // pin synchronisers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      code_s1 <= '0;
      code_s2 <= '0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end
    else
    begin
      code_s1 <= voltage_code_in;
      code_s2 <= code_s1;
      en_s1 <= enable_in;
      en_s2 <= en_s1;
      mode_s1 <= stepwise_mode_in;
      mode_s2 <= mode_s1;
    end
  end

  // candidate qualification on each sampling edge
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cand <= '0;
      cnt <= '0;
    end
    else if (sample_tick)
    begin
      if (code_s2 != cand)
      begin
        cand <= code_s2;
        cnt <= 3'(1);
      end
      else if (cnt != OFFQ)
        cnt <= cnt + 3'(1);
    end
  end

  assign off_seen = sample_tick && code_s2 == cand && cnt == OFFQ - 3'(1)
                    && is_off(cand, mode_s2);
  assign accepted = sample_tick && code_s2 == cand && cnt == QUAL - 3'(1)
                    && !is_off(cand, mode_s2);
  assign new_req = accepted && cand != target;
  // current candidate already qualified and not an off code
  assign qualified = cnt >= QUAL && !is_off(cand, mode_s2);

  // last three samples, kept for the qualification checks
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      hist_1 <= '0;
      hist_2 <= '0;
      hist_3 <= '0;
    end
    else if (sample_tick)
    begin
      hist_1 <= code_s2;
      hist_2 <= hist_1;
      hist_3 <= hist_2;
    end
  end

  // accepted target
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      target <= '0;
    else if (accepted)
      target <= cand;
  end

  // enable, run and off latch
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      state <= vcrs_pkg::VCRS_IDLE;
    else if (!en_s2)
      state <= vcrs_pkg::VCRS_IDLE;
    else
    begin
      unique case (state)
        vcrs_pkg::VCRS_IDLE:
          if (off_seen)
            state <= vcrs_pkg::VCRS_OFF;
          else if (qualified && !(!mode_s2 && cand == NOLOAD))
            state <= vcrs_pkg::VCRS_RUN;
        vcrs_pkg::VCRS_RUN:
          if (off_seen)
            state <= vcrs_pkg::VCRS_OFF;
        vcrs_pkg::VCRS_OFF:
          state <= vcrs_pkg::VCRS_OFF;
      endcase
    end
  end

  // dac movement
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      dac_code_out <= '0;
    else if (state != vcrs_pkg::VCRS_RUN)
      dac_code_out <= dac_code_out;
    else if (mode_s2)
    begin
      if (accepted)
        dac_code_out <= cand;
      else if (dac_code_out != target)
        dac_code_out <= target;
    end
    else if (step_tick && dac_code_out != target)
    begin
      if (dac_code_out < target)
        dac_code_out <= dac_code_out + CODE_W'(1);
      else
        dac_code_out <= dac_code_out - CODE_W'(1);
    end
  end

  // status outputs
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      regulate_out <= 1'b0;
      off_latched_out <= 1'b0;
      power_good_flag_out <= 1'b0;
    end
    else
    begin
      regulate_out <= (state == vcrs_pkg::VCRS_RUN) && !off_seen;
      off_latched_out <= (state == vcrs_pkg::VCRS_OFF);
      power_good_flag_out <= (state == vcrs_pkg::VCRS_RUN) && !off_seen
                             && dac_code_out == target;
    end
  end

  a_off_latch_holds: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state == vcrs_pkg::VCRS_OFF && en_s2 |=> state == vcrs_pkg::VCRS_OFF)
    else $error("off latch released while enabled");
  a_power_good_flag_low_off: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state == vcrs_pkg::VCRS_OFF |=> !power_good_flag_out)
    else $error("power good high while latched off");
  a_step_load_now: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    accepted && mode_s2 && state == vcrs_pkg::VCRS_RUN
    |=> dac_code_out == $past(cand))
    else $error("stepwise dac not loaded");
  a_slew_one_step: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !mode_s2 && $past(!mode_s2) && dac_code_out != $past(dac_code_out)
    |-> (dac_code_out - $past(dac_code_out) == CODE_W'(1))
     || ($past(dac_code_out) - dac_code_out == CODE_W'(1)))
    else $error("slew moved more than one step");
  a_slew_on_tick: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !mode_s2 && !step_tick |=> $stable(dac_code_out) || $past(mode_s2))
    else $error("slew moved without step tick");
  a_accept_three: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    accepted |-> sample_tick && hist_1 == code_s2 && hist_2 == code_s2)
    else $error("accepted without three samples");
  a_off_four: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    off_seen |-> sample_tick && hist_1 == code_s2 && hist_2 == code_s2
    && hist_3 == code_s2)
    else $error("off code recognised early");
  a_count_restart: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    sample_tick && code_s2 != cand |=> cnt == 3'(1))
    else $error("count not restarted");
  a_noload_block: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state == vcrs_pkg::VCRS_IDLE && !mode_s2 && cand == NOLOAD
    |=> state != vcrs_pkg::VCRS_RUN)
    else $error("start with no-load code");
  a_sample_only_tick: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !sample_tick |=> $stable(cnt) && $stable(cand))
    else $error("sample taken off tick");
  c_new_req: cover property (@(posedge clk_in) disable iff (!rst_n_in) new_req);
  c_off: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    state == vcrs_pkg::VCRS_OFF);
  c_power_good_flag: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    power_good_flag_out && !mode_s2);
endmodule : vcrs_top

/* sim/vcrs_cpu_model.sv */
// processor model that drives the voltage code pins toward a target
// assumes the bench sets target, mode and jump after a rising edge
`timescale 1ns/1ns
module vcrs_cpu_model (
  // clock
  input wire logic clk_in,
  // commands from the bench
  input wire logic [7:0] target_in,
  input wire logic stepwise_in,
  input wire logic jump_in,
  // code pins
  output logic [7:0] voltage_code_out
);
  logic [3:0] gap = 4'h0;
  initial voltage_code_out = 8'h40;
  // one step at a time in stepwise mode unless jump_in is set, then a 1 us pause
  always @(posedge clk_in)
  begin
    if (gap != 4'h0)
    begin
      gap <= gap - 4'h1;
    end
    else if (voltage_code_out != target_in)
    begin
      gap <= (stepwise_in && !jump_in) ? 4'ha : 4'h0;
      if (!stepwise_in || jump_in)
      begin
        voltage_code_out <= target_in;
      end
      else if (target_in > voltage_code_out)
      begin
        voltage_code_out <= voltage_code_out + 8'h01;
      end
      else
      begin
        voltage_code_out <= voltage_code_out - 8'h01;
      end
    end
  end
endmodule : vcrs_cpu_model

/* sim/vcrs_top_tb.sv */
// self-checking bench for the voltage code reference stepper
// assumes vcrs_params.svh on the include path
`timescale 1ns/1ns
`include "vcrs_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module vcrs_top_tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic mode = 1'b1;
  logic jump = 1'b0;
  logic [7:0] target = 8'h40;
  logic [7:0] code;
  logic [7:0] dac;
  logic reg_on, off_on, pg;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  initial forever #50 clk_in = ~clk_in;
  vcrs_cpu_model u_cpu (.clk_in(clk_in), .target_in(target),
    .stepwise_in(mode), .jump_in(jump), .voltage_code_out(code));
  vcrs_top u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .enable_in(enable_in), .stepwise_mode_in(mode),
    .voltage_code_in(code), .dac_code_out(dac), .regulate_out(reg_on),
    .off_latched_out(off_on), .power_good_flag_out(pg));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wait_dac(input logic [7:0] e, input int lim);
    n = 0;
    while (dac !== e && n < lim)
    begin
      cyc(1);
      n++;
    end
    `CHK("dac", e, dac)
  endtask : wait_dac
  task automatic t_step;
    @(posedge clk_in) enable_in <= 1'b1;
    wait_dac(8'h40, 30);
    cyc(2);
    `CHK("pg", 1'b1, pg)
    @(posedge clk_in) target <= 8'h41;
    cyc(5);
    `CHK("early", 8'h40, dac)
    wait_dac(8'h41, 30);
    @(posedge clk_in) jump <= 1'b1;
    target <= 8'h42;
    cyc(3);
    @(posedge clk_in) target <= 8'h41;
    cyc(30);
    `CHK("glitch", 8'h41, dac)
    @(posedge clk_in) target <= 8'h50;
    wait_dac(8'h50, 20);
  endtask : t_step
  task automatic t_slew;
    @(posedge clk_in) mode <= 1'b0;
    jump <= 1'b0;
    cyc(5);
    @(posedge clk_in) target <= 8'h54;
    wait_dac(8'h51, 60);
    wait_dac(8'h52, 40);
    `CHK("step", `VCRS_STEP_DIV, n)
    `CHK("pg_mid", 1'b0, pg)
    @(posedge clk_in) target <= 8'h4e;
    wait_dac(8'h4e, 400);
  endtask : t_slew
  task automatic t_off;
    @(posedge clk_in) mode <= 1'b1;
    jump <= 1'b1;
    cyc(5);
    @(posedge clk_in) target <= 8'h00;
    cyc(7);
    `CHK("off_early", 1'b0, off_on)
    cyc(20);
    `CHK("off", 1'b1, off_on)
    `CHK("reg_off", 1'b0, reg_on)
    `CHK("pg_off", 1'b0, pg)
    @(posedge clk_in) target <= 8'h40;
    cyc(30);
    `CHK("held", 1'b1, off_on)
    @(posedge clk_in) enable_in <= 1'b0;
    cyc(10);
    `CHK("cleared", 1'b0, off_on)
    `CHK("pg_low", 1'b0, pg)
    @(posedge clk_in) enable_in <= 1'b1;
    wait_dac(8'h40, 30);
    cyc(2);
    `CHK("pg_back", 1'b1, pg)
    `CHK("reg_back", 1'b1, reg_on)
  endtask : t_off
  task automatic t_noload;
    @(posedge clk_in) enable_in <= 1'b0;
    mode <= 1'b0;
    target <= 8'h1f;
    cyc(10);
    @(posedge clk_in) enable_in <= 1'b1;
    cyc(40);
    `CHK("noload", 1'b0, reg_on)
  endtask : t_noload
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    #1_000_000;
    n_errors++;
    test_done();
  end
  initial
  begin
    cyc(5);
    @(posedge clk_in) rst_n_in <= 1'b1;
    cyc(2);
    t_step();
    t_slew();
    t_off();
    t_noload();
    test_done();
  end
endmodule : vcrs_top_tb
